// File: iam_top.sv
// Slave address matching with masking and repeated-start bus-collision master
`timescale 1ns/1ps
`default_nettype none
module iam_top
(
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic [7:0] own_address_reg,
    input  wire logic [4:0] address_mask_field,
    input  wire logic [1:0] upper_address_bits,
    input  wire logic       ten_bit_mode,
    input  wire logic       slave_enable,
    input  wire logic       rstart_req,
    input  wire logic       collision_clear,
    output logic [7:0]      receive_buffer_reg,
    output logic            port_irq,
    output logic            bus_collision_flag,
    output logic            rstart_busy,
    output logic            rstart_done
);
    // ==========================================================
    // Pin synchronisers
    logic scl_meta_r, scl_s_r, scl_q_r;
    logic sda_meta_r, sda_s_r, sda_q_r;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            scl_meta_r <= 1'b1;
            scl_s_r    <= 1'b1;
            scl_q_r    <= 1'b1;
            sda_meta_r <= 1'b1;
            sda_s_r    <= 1'b1;
            sda_q_r    <= 1'b1;
        end
        else
        begin
            scl_meta_r <= scl_in;
            scl_s_r    <= scl_meta_r;
            scl_q_r    <= scl_s_r;
            sda_meta_r <= sda_in;
            sda_s_r    <= sda_meta_r;
            sda_q_r    <= sda_s_r;
        end
    end

    logic scl_rise, scl_fall, sda_fall, sda_rise;
    assign scl_rise = scl_s_r & ~scl_q_r;
    assign scl_fall = ~scl_s_r & scl_q_r;
    assign sda_fall = ~sda_s_r & sda_q_r;
    assign sda_rise = sda_s_r & ~sda_q_r;

    // ==========================================================
    // Slave address receiver
    iam_pkg::iam_slave_e sl_state_r, sl_state_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [2:0] bit_cnt_r, bit_cnt_nxt;
    logic       hi_seen_r, hi_seen_nxt;
    logic       ack_arm_r, ack_arm_nxt;
    logic       ack_drive_r, ack_drive_nxt;
    logic       last_r, last_nxt;
    logic [7:0] rx_buf_r, rx_buf_nxt;
    logic       addr_irq_r, addr_irq_nxt;
    logic [7:0] byte_w;
    logic       match_w, byte_done, high_phase;

    assign byte_w     = {shift_r[6:0], sda_s_r};
    assign byte_done  = (sl_state_r == iam_pkg::SL_ADDR) && scl_rise && (bit_cnt_r == iam_pkg::LAST_BIT);
    assign high_phase = ten_bit_mode & ~hi_seen_r;

    iam_addr_match u_match
    (
        .rx_byte            (byte_w),
        .own_address_reg    (own_address_reg),
        .address_mask_field (address_mask_field),
        .upper_address_bits (upper_address_bits),
        .ten_bit_mode       (ten_bit_mode),
        .high_phase         (high_phase),
        .match              (match_w)
    );

    always_comb
    begin
        sl_state_nxt  = sl_state_r;
        shift_nxt     = shift_r;
        bit_cnt_nxt   = bit_cnt_r;
        hi_seen_nxt   = hi_seen_r;
        ack_arm_nxt   = ack_arm_r;
        ack_drive_nxt = ack_drive_r;
        last_nxt      = last_r;
        rx_buf_nxt    = rx_buf_r;
        addr_irq_nxt  = 1'b0;
        unique case (sl_state_r)
            iam_pkg::SL_IDLE, iam_pkg::SL_HOLD:
            begin
                ack_drive_nxt = 1'b0;
            end
            iam_pkg::SL_ADDR:
            begin
                if (scl_rise)
                begin
                    shift_nxt   = byte_w;
                    bit_cnt_nxt = bit_cnt_r + 3'h1;
                end
                if (byte_done)
                begin
                    ack_arm_nxt = match_w;
                    last_nxt    = ~high_phase;
                    if (match_w && !high_phase)
                    begin
                        // Buffer keeps the matched byte so software can tell which address hit
                        rx_buf_nxt   = byte_w;
                        addr_irq_nxt = 1'b1;
                    end
                    sl_state_nxt = match_w ? iam_pkg::SL_ACK : iam_pkg::SL_HOLD;
                end
            end
            iam_pkg::SL_ACK:
            begin
                if (scl_fall && !ack_drive_r)
                begin
                    ack_drive_nxt = 1'b1;
                end
                else if (scl_fall)
                begin
                    ack_drive_nxt = 1'b0;
                    ack_arm_nxt   = 1'b0;
                    hi_seen_nxt   = 1'b1;
                    bit_cnt_nxt   = 3'h0;
                    sl_state_nxt  = last_r ? iam_pkg::SL_HOLD : iam_pkg::SL_ADDR;
                end
            end
            default:
            begin
                sl_state_nxt = iam_pkg::SL_IDLE;
            end
        endcase
        // Stop and disable override any state, as does a start while rstart_busy is low; data phase is outside this block
        if (!slave_enable || (sda_rise && scl_s_r))
        begin
            sl_state_nxt  = iam_pkg::SL_IDLE;
            ack_drive_nxt = 1'b0;
            ack_arm_nxt   = 1'b0;
        end
        else if (sda_fall && scl_s_r && !rstart_busy)
        begin
            sl_state_nxt  = iam_pkg::SL_ADDR;
            bit_cnt_nxt   = 3'h0;
            hi_seen_nxt   = 1'b0;
            ack_drive_nxt = 1'b0;
            ack_arm_nxt   = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            sl_state_r  <= iam_pkg::SL_IDLE;
            shift_r     <= iam_pkg::RX_BUF_RST;
            bit_cnt_r   <= 3'h0;
            hi_seen_r   <= 1'b0;
            ack_arm_r   <= 1'b0;
            ack_drive_r <= 1'b0;
            last_r      <= 1'b0;
            rx_buf_r    <= iam_pkg::RX_BUF_RST;
            addr_irq_r  <= 1'b0;
        end
        else
        begin
            sl_state_r  <= sl_state_nxt;
            shift_r     <= shift_nxt;
            bit_cnt_r   <= bit_cnt_nxt;
            hi_seen_r   <= hi_seen_nxt;
            ack_arm_r   <= ack_arm_nxt;
            ack_drive_r <= ack_drive_nxt;
            last_r      <= last_nxt;
            rx_buf_r    <= rx_buf_nxt;
            addr_irq_r  <= addr_irq_nxt;
        end
    end

    // ==========================================================
    // Repeated start generator with collision checks
    iam_pkg::iam_rstart_e rs_state_r, rs_state_nxt;
    logic [6:0] baud_countdown_r, baud_countdown_nxt;
    logic       m_scl_r, m_scl_nxt;
    logic       m_sda_r, m_sda_nxt;
    logic       coll_set, coll_flag_r, coll_flag_nxt;
    logic       coll_irq_r, done_r, done_nxt;
    logic       baud_zero;

    assign baud_zero = (baud_countdown_r == 7'h00);

    always_comb
    begin
        rs_state_nxt       = rs_state_r;
        baud_countdown_nxt = baud_zero ? baud_countdown_r : baud_countdown_r - 7'h01;
        m_scl_nxt          = m_scl_r;
        m_sda_nxt          = m_sda_r;
        coll_set           = 1'b0;
        done_nxt           = 1'b0;
        unique case (rs_state_r)
            iam_pkg::RS_IDLE:
            begin
                if (rstart_req)
                begin
                    m_scl_nxt          = 1'b1;
                    m_sda_nxt          = 1'b0;
                    baud_countdown_nxt = own_address_reg[6:0];
                    rs_state_nxt       = iam_pkg::RS_WAIT1;
                end
            end
            iam_pkg::RS_WAIT1:
            begin
                if (baud_zero)
                begin
                    m_scl_nxt    = 1'b0;
                    rs_state_nxt = iam_pkg::RS_SCLH;
                end
            end
            iam_pkg::RS_SCLH:
            begin
                if (scl_s_r && !sda_s_r)
                begin
                    coll_set = 1'b1;
                end
                else if (scl_s_r)
                begin
                    baud_countdown_nxt = own_address_reg[6:0];
                    rs_state_nxt       = iam_pkg::RS_WAIT2;
                end
            end
            iam_pkg::RS_WAIT2:
            begin
                // An SDA fall is ignored until count end, where low SDA is a collision: two masters never pull at the same instant
                if (scl_fall)
                begin
                    coll_set = 1'b1;
                end
                else if (baud_zero && scl_s_r && sda_s_r)
                begin
                    m_sda_nxt          = 1'b1;
                    baud_countdown_nxt = own_address_reg[6:0];
                    rs_state_nxt       = iam_pkg::RS_WAIT3;
                end
                else if (baud_zero && !sda_s_r)
                begin
                    coll_set = 1'b1;
                end
            end
            iam_pkg::RS_WAIT3:
            begin
                if (baud_zero)
                begin
                    m_scl_nxt    = 1'b1;
                    done_nxt     = 1'b1;
                    rs_state_nxt = iam_pkg::RS_IDLE;
                end
            end
            default:
            begin
                rs_state_nxt = iam_pkg::RS_IDLE;
            end
        endcase
        if (coll_set)
        begin
            m_scl_nxt    = 1'b0;
            m_sda_nxt    = 1'b0;
            rs_state_nxt = iam_pkg::RS_IDLE;
        end
        // A new collision beats a clear in the same cycle
        coll_flag_nxt = coll_set | (coll_flag_r & ~collision_clear);
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            rs_state_r       <= iam_pkg::RS_IDLE;
            baud_countdown_r <= iam_pkg::BAUD_RST;
            m_scl_r          <= 1'b0;
            m_sda_r          <= 1'b0;
            coll_flag_r      <= 1'b0;
            coll_irq_r       <= 1'b0;
            done_r           <= 1'b0;
        end
        else
        begin
            rs_state_r       <= rs_state_nxt;
            baud_countdown_r <= baud_countdown_nxt;
            m_scl_r          <= m_scl_nxt;
            m_sda_r          <= m_sda_nxt;
            coll_flag_r      <= coll_flag_nxt;
            coll_irq_r       <= coll_set;
            done_r           <= done_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign scl_out            = 1'b0;
    assign sda_out            = 1'b0;
    assign scl_oe             = m_scl_r;
    assign sda_oe             = m_sda_r | ack_drive_r;
    assign receive_buffer_reg = rx_buf_r;
    assign port_irq           = addr_irq_r | coll_irq_r;
    assign bus_collision_flag = coll_flag_r;
    assign rstart_busy        = (rs_state_r != iam_pkg::RS_IDLE);
    assign rstart_done        = done_r;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_wait2_exp;
        (rs_state_r == iam_pkg::RS_WAIT2) && baud_zero && scl_s_r && sda_s_r && !scl_fall;
    endsequence
    sequence s_driven_reload;
        m_sda_r && (baud_countdown_r == own_address_reg[6:0]) && (rs_state_r == iam_pkg::RS_WAIT3);
    endsequence

    property p_mask7;
        byte_done && !ten_bit_mode &&
            (((byte_w[7:1] ^ own_address_reg[7:1]) & {2'h3, ~address_mask_field}) == 7'h00) |=> ack_arm_r;
    endproperty
    a_mask7: assert property (p_mask7) else $error("masked 7-bit address not acknowledged");

    property p_nomatch;
        byte_done && !match_w |=> !ack_arm_r && (sl_state_r != iam_pkg::SL_ACK);
    endproperty
    a_nomatch: assert property (p_nomatch) else $error("unmatched address acknowledged");

    property p_rxbuf;
        byte_done && match_w && !high_phase |=> port_irq && (receive_buffer_reg == $past(byte_w));
    endproperty
    a_rxbuf: assert property (p_rxbuf) else $error("matched address not buffered or no interrupt");

    property p_hi_exact;
        byte_done && high_phase && (byte_w[2:1] != upper_address_bits) |=> !ack_arm_r;
    endproperty
    a_hi_exact: assert property (p_hi_exact) else $error("10-bit upper bits not compared exactly");

    property p_lowpair;
        byte_done && ten_bit_mode && !high_phase && address_mask_field[0] &&
            (((byte_w ^ own_address_reg) & {2'h3, ~address_mask_field[4:1], 2'h0}) == 8'h00) |=> ack_arm_r;
    endproperty
    a_lowpair: assert property (p_lowpair) else $error("low pair mask ineffective");

    property p_sda_low_coll;
        (rs_state_r == iam_pkg::RS_SCLH) && scl_s_r && !sda_s_r |=> bus_collision_flag && !scl_oe && !m_sda_r;
    endproperty
    a_sda_low_coll: assert property (p_sda_low_coll) else $error("SDA low at SCL high not flagged");

    property p_scl_release;
        (rs_state_r == iam_pkg::RS_WAIT1) && baud_zero |=> !scl_oe && (rs_state_r == iam_pkg::RS_SCLH);
    endproperty
    a_scl_release: assert property (p_scl_release) else $error("SCL not released at count end");

    property p_sda_fall_ok;
        (rs_state_r == iam_pkg::RS_WAIT2) && !baud_zero && !scl_fall && sda_fall |=>
            !$rose(bus_collision_flag) && (rs_state_r == iam_pkg::RS_WAIT2);
    endproperty
    a_sda_fall_ok: assert property (p_sda_fall_ok) else $error("SDA fall taken as collision");

    property p_scl_fall_coll;
        (rs_state_r == iam_pkg::RS_WAIT2) && scl_fall |=> bus_collision_flag && port_irq && !rstart_busy;
    endproperty
    a_scl_fall_coll: assert property (p_scl_fall_coll) else $error("early SCL fall not flagged");

    property p_drive_sda;
        s_wait2_exp |=> s_driven_reload;
    endproperty
    a_drive_sda: assert property (p_drive_sda) else $error("SDA not driven with reload");

    property p_finish;
        (rs_state_r == iam_pkg::RS_WAIT3) && baud_zero |=> scl_oe && rstart_done ##1 !rstart_done;
    endproperty
    a_finish: assert property (p_finish) else $error("repeated start not completed");

    property p_flag_hold;
        bus_collision_flag && !collision_clear |=> bus_collision_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("collision flag lost");
endmodule // iam_top
`default_nettype wire

// File: iam_pkg.sv
// Constants and types for the address-mask and repeated-start collision block
package iam_pkg;
    // ==========================================================
    // Field layout
    localparam int         BAUD_W         = 7;
    localparam int         MASK_W         = 5;
    localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
    localparam logic [2:0] LAST_BIT       = 3'h7;
    // ==========================================================
    // Reset values
    localparam logic [7:0] RX_BUF_RST     = 8'h00;
    localparam logic [6:0] BAUD_RST       = 7'h00;
    // Bench link clock period, informative only
    localparam int         LINK_PERIOD_NS = 80;
    // ==========================================================
    // States
    typedef enum logic [2:0] {SL_IDLE, SL_ADDR, SL_ACK, SL_HOLD} iam_slave_e;
    typedef enum logic [2:0] {RS_IDLE, RS_WAIT1, RS_SCLH, RS_WAIT2, RS_WAIT3} iam_rstart_e;
endpackage

// File: iam_addr_match.sv
// Masked own-address comparator for 7-bit and 10-bit slave addressing
`timescale 1ns/1ps
`default_nettype none
module iam_addr_match
(
    input  wire logic [7:0] rx_byte,
    input  wire logic [7:0] own_address_reg,
    input  wire logic [4:0] address_mask_field,
    input  wire logic [1:0] upper_address_bits,
    input  wire logic       ten_bit_mode,
    input  wire logic       high_phase,
    output logic            match
);
    logic [7:0] care;
    logic [7:0] diff;

    always_comb
    begin
        care = 8'hff;
        diff = rx_byte ^ own_address_reg;
        match = 1'b0;
        if (!ten_bit_mode)
        begin
            care  = {2'h3, ~address_mask_field, 1'h0};
            match = ((diff & care) == 8'h00);
        end
        else if (high_phase)
        begin
            // High byte carries prefix and the two top bits, never masked
            match = (rx_byte[7:3] == iam_pkg::TEN_BIT_PREFIX) && (rx_byte[2:1] == upper_address_bits);
        end
        else
        begin
            care  = {2'h3, ~address_mask_field[4:1], {2{~address_mask_field[0]}}};
            match = ((diff & care) == 8'h00);
        end
    end
endmodule // iam_addr_match
`default_nettype wire

// File: iam_far_end.sv
// Behavioural far-side I2C party: an addressing master or a rival master
`timescale 1ns/1ps
`default_nettype none
module iam_far_end
(
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_low,
    output logic      sda_low
);
    // ==========================================================
    // Bus driving
    // Half of the 80 ns link period; SCL stands still between frames
    localparam int HALF = 40;
    initial
    begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic pull(input logic c, input logic d);
        scl_low = c;
        sda_low = d;
    endtask
    task automatic start_cond();
        pull(1'b0, 1'b0);
        #(HALF) sda_low = 1'b1;
        #(HALF);
    endtask
    // Data moves only while SCL is low, MSB first
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            scl_low = 1'b1;
            #10 sda_low = ~b[i];
            #(HALF-10) scl_low = 1'b0;
            #(HALF);
        end
        scl_low = 1'b1;
        #10 sda_low = 1'b0;
        #(HALF-10) scl_low = 1'b0;
        #20 ack = (sda === 1'b0);
        #20 scl_low = 1'b1;
        #(HALF);
    endtask
    task automatic stop_cond();
        sda_low = 1'b1;
        #20 scl_low = 1'b0;
        #(HALF) sda_low = 1'b0;
        #(HALF);
    endtask
endmodule // iam_far_end
`default_nettype wire

// File: iam_top_bench.sv
// Self-checking bench for address masking and repeated-start collisions
`timescale 1ns/1ps
`default_nettype none
module iam_top_bench;
    // ==========================================================
    // Signals
    logic       clk_sys;
    logic       reset;
    wire logic  scl;
    wire logic  sda;
    logic       scl_oe;
    logic       sda_oe;
    logic       scl_out;
    logic       sda_out;
    logic [7:0] own_address_reg;
    logic [4:0] address_mask_field;
    logic [1:0] upper_address_bits;
    logic       ten_bit_mode;
    logic       slave_enable;
    logic       rstart_req;
    logic       collision_clear;
    logic [7:0] receive_buffer_reg;
    logic       port_irq;
    logic       bus_collision_flag;
    logic       rstart_busy;
    logic       rstart_done;
    logic       m_scl_low;
    logic       m_sda_low;
    logic [7:0] last_buf;
    int         fails;
    int         compares;
    int         irq_cnt;
    // Open-drain lines with pull-ups
    assign scl = ~(scl_oe | m_scl_low);
    assign sda = ~(sda_oe | m_sda_low);
    // ==========================================================
    // Instances
    iam_top u_iam_top
    (
        .clk_sys            (clk_sys),
        .reset              (reset),
        .scl_in             (scl),
        .scl_out            (scl_out),
        .scl_oe             (scl_oe),
        .sda_in             (sda),
        .sda_out            (sda_out),
        .sda_oe             (sda_oe),
        .own_address_reg    (own_address_reg),
        .address_mask_field (address_mask_field),
        .upper_address_bits (upper_address_bits),
        .ten_bit_mode       (ten_bit_mode),
        .slave_enable       (slave_enable),
        .rstart_req         (rstart_req),
        .collision_clear    (collision_clear),
        .receive_buffer_reg (receive_buffer_reg),
        .port_irq           (port_irq),
        .bus_collision_flag (bus_collision_flag),
        .rstart_busy        (rstart_busy),
        .rstart_done        (rstart_done)
    );
    iam_far_end u_iam_far_end
    (
        .scl     (scl),
        .sda     (sda),
        .scl_low (m_scl_low),
        .sda_low (m_sda_low)
    );
    // ==========================================================
    // Clock, monitor and helpers
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
        if (port_irq === 1'b1)
            irq_cnt <= irq_cnt + 1;
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        if (fails == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // One addressing frame; a high byte is sent first in 10-bit mode
    task automatic frame(input logic [7:0] hi, input logic [7:0] lo, input logic exp_hi, input logic exp_lo);
        logic ack;
        int   irq0;
        irq0 = irq_cnt;
        u_iam_far_end.start_cond();
        if (ten_bit_mode)
        begin
            u_iam_far_end.send_byte(hi, ack);
            check("high byte ack", exp_hi, ack);
        end
        if (!ten_bit_mode || exp_hi)
        begin
            u_iam_far_end.send_byte(lo, ack);
            check("address ack", exp_lo, ack);
        end
        u_iam_far_end.stop_cond();
        if (exp_lo)
            last_buf = lo;
        check("irq count", 8'(exp_lo), 8'(irq_cnt - irq0));
        check("receive buffer", last_buf, receive_buffer_reg);
    endtask
    // ==========================================================
    // Scenarios
    task automatic test_reset();
        check("reset oe", 8'h00, {scl_out, sda_out, scl_oe, sda_oe, rstart_busy, bus_collision_flag, port_irq});
        check("reset buffer", iam_pkg::RX_BUF_RST, receive_buffer_reg);
    endtask
    task automatic test_mask7();
        logic [7:0] b;
        own_address_reg = 8'ha0;
        address_mask_field = 5'h07;
        slave_enable = 1'b1;
        for (int i = 8'h9e; i <= 8'hb2; i += 2)
        begin
            b = 8'(i);
            frame(8'h00, b, 1'b0, ((b ^ own_address_reg) & {2'h3, ~address_mask_field, 1'b0}) == 8'h00);
        end
        address_mask_field = 5'h00;
        frame(8'h00, 8'ha1, 1'b0, 1'b1);
        frame(8'h00, 8'ha2, 1'b0, 1'b0);
        slave_enable = 1'b0;
        frame(8'h00, 8'ha0, 1'b0, 1'b0);
    endtask
    task automatic test_mask10();
        logic [7:0] b;
        logic [7:0] m;
        logic [7:0] hi;
        ten_bit_mode = 1'b1;
        upper_address_bits = 2'h2;
        address_mask_field = 5'h07;
        slave_enable = 1'b1;
        hi = {iam_pkg::TEN_BIT_PREFIX, 2'h2, 1'b0};
        m = {2'h0, address_mask_field[4:1], {2{address_mask_field[0]}}};
        for (int i = 8'h9e; i <= 8'hb0; i++)
        begin
            b = 8'(i);
            frame(hi, b, 1'b1, ((b ^ own_address_reg) & ~m) == 8'h00);
        end
        frame({iam_pkg::TEN_BIT_PREFIX, 2'h1, 1'b0}, 8'ha0, 1'b0, 1'b0);
        address_mask_field = 5'h1f;
        frame(hi, 8'h60, 1'b1, 1'b0);
        frame(hi, 8'h9f, 1'b1, 1'b1);
        slave_enable = 1'b0;
        ten_bit_mode = 1'b0;
    endtask
    // kind: 0 clean, 1 rival holds SDA low, 2 rival pulls SCL early, 3 brief SDA low
    task automatic run_rstart(input int kind, input logic exp_coll);
        int n;
        int nsda;
        int irq0;
        int cnt;
        n = 0;
        nsda = -1;
        irq0 = irq_cnt;
        cnt = int'(own_address_reg[6:0]);
        tick();
        rstart_req = 1'b1;
        tick();
        rstart_req = 1'b0;
        repeat (cnt) tick();
        check("scl held low", 8'h01, scl_oe);
        tick();
        check("scl released", 8'h00, scl_oe);
        case (kind)
            1: u_iam_far_end.pull(1'b0, 1'b1);
            2:
            begin
                repeat (10) tick();
                u_iam_far_end.pull(1'b1, 1'b0);
            end
            3:
            begin
                repeat (10) tick();
                u_iam_far_end.pull(1'b0, 1'b1);
                repeat (5) tick();
                u_iam_far_end.pull(1'b0, 1'b0);
            end
            default: ;
        endcase
        while (n < 400 && rstart_done !== 1'b1 && bus_collision_flag !== 1'b1)
        begin
            if (sda_oe === 1'b1 && nsda < 0)
                nsda = n;
            tick();
            n++;
        end
        check("collision flag", exp_coll, bus_collision_flag);
        if (exp_coll)
        begin
            check("lines after collision", 8'h00, {scl_oe, sda_oe});
            tick();
            check("collision irq", 8'h01, 8'(irq_cnt - irq0));
            check("busy after collision", 8'h00, rstart_busy);
        end
        else
        begin
            check("lines held", 8'h03, {scl_oe, sda_oe});
            check("last count", 8'(cnt + 1), 8'(n - nsda));
            check("done pulse", 8'h01, rstart_done);
            tick();
            check("done and busy after", 8'h00, {rstart_done, rstart_busy});
        end
        u_iam_far_end.pull(1'b0, 1'b0);
        collision_clear = 1'b1;
        tick();
        collision_clear = 1'b0;
        check("flag cleared", 8'h00, bus_collision_flag);
    endtask
    task automatic test_rstart_ok();
        own_address_reg = 8'ha0;
        run_rstart(0, 1'b0);
        own_address_reg = 8'h83;
        run_rstart(0, 1'b0);
    endtask
    task automatic test_rstart_coll();
        own_address_reg = 8'ha0;
        run_rstart(1, 1'b1);
        run_rstart(2, 1'b1);
        run_rstart(3, 1'b0);
    endtask
    // ==========================================================
    // Main sequence and watchdog
    initial
    begin
        reset = 1'b1;
        own_address_reg = 8'h00;
        address_mask_field = 5'h00;
        upper_address_bits = 2'h0;
        ten_bit_mode = 1'b0;
        slave_enable = 1'b0;
        rstart_req = 1'b0;
        collision_clear = 1'b0;
        last_buf = iam_pkg::RX_BUF_RST;
        fails = 0;
        compares = 0;
        irq_cnt = 0;
        repeat (10) @(posedge clk_sys);
        #1 reset = 1'b0;
        tick();
        test_reset();
        test_mask7();
        test_mask10();
        test_rstart_ok();
        test_rstart_coll();
        finish_test();
    end
    initial
    begin
        #200000;
        fails++;
        finish_test();
    end
endmodule // iam_top_bench
`default_nettype wire
